// >>> inc/memspace_pkg.sv
// constants and types for the core memory space decoder
package memspace_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          PC_W            = 16;
  localparam int          PAGE_BITS       = 11;
  localparam int          REC_W           = 32;
  localparam logic [7:0]  DIRECT_SPLIT    = 8'h80;
  localparam logic [7:0]  BANK_TOP        = 8'h1F;
  localparam logic [7:0]  BITRAM_BASE     = 8'h20;
  localparam logic [7:0]  STACK_PTR_ADDR  = 8'h81;
  localparam logic [7:0]  STACK_PTR_RESET = 8'h07;
  localparam logic [7:0]  STATUS_ADDR     = 8'hD0;
  localparam logic [7:0]  PSTORE_ADDR     = 8'h8F;
  localparam int          BANK_LO_BIT     = 3;
  localparam int          BANK_HI_BIT     = 4;
  localparam int          PSTORE_WE_BIT   = 0;
  localparam logic [15:0] FLASH_LAST      = 16'h807F;
  localparam logic [15:0] FACTORY_FIRST   = 16'h7E00;
  localparam logic [15:0] FACTORY_LAST    = 16'h7FFF;
  localparam logic [7:0]  OPC_NOP         = 8'h00;
  localparam logic [7:0]  OPC_SPARE_NOP   = 8'hA5;

  typedef enum logic [2:0] {
    JUMP_NONE, JUMP_REL, JUMP_PAGE, JUMP_LONG
  } jump_kind_t;

  typedef enum logic [2:0] {
    ACC_NONE, ACC_DIRECT, ACC_INDIRECT, ACC_REG, ACC_BIT, ACC_EXT, ACC_CODE
  } access_kind_t;

  typedef enum logic [2:0] {
    STK_NONE, STK_PUSH, STK_POP, STK_INC, STK_DEC, STK_CALL, STK_RET
  } stack_op_t;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_LOW_RAM, TGT_HIGH_RAM, TGT_SFR, TGT_PROG, TGT_XDATA
  } target_t;
endpackage

// >>> rtl/jump_target.sv
// branch destination calculation for relative, page and long jumps
`timescale 1ns/100ps
module jump_target (
  input  wire memspace_pkg::jump_kind_t kind_i,
  input  wire logic [15:0]              next_pc_i,
  input  wire logic [15:0]              operand_i,
  output logic      [15:0]              target_o
);
  import memspace_pkg::*;
  always_comb begin
    case (kind_i)
      // [R01] signed rel offset
      JUMP_REL:  target_o = next_pc_i + {{8{operand_i[7]}}, operand_i[7:0]};
      // [R03] same 2K page
      JUMP_PAGE: target_o = {next_pc_i[15:PAGE_BITS],
                             operand_i[PAGE_BITS-1:0]};
      // [R04] full 16-bit target
      JUMP_LONG: target_o = operand_i;
      default:   target_o = next_pc_i;
    endcase
  end
endmodule

// >>> rtl/stack_record.sv
// stack record shift register with overflow and underflow flags
`timescale 1ns/100ps
module stack_record #(
  parameter int DEPTH = 32
) (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire memspace_pkg::stack_op_t op_i,
  output logic                        overflow_o,
  output logic                        underflow_o,
  output logic [DEPTH-1:0]            record_o
);
  import memspace_pkg::*;
  typedef struct packed {
    logic [DEPTH-1:0] bits;
    logic [5:0]       fill;
    logic             ovf;
    logic             unf;
  } rec_state_t;
  rec_state_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.ovf = 1'b0;
    s_nxt.unf = 1'b0;
    case (op_i)
      // [R18] one bit in per push
      STK_PUSH, STK_INC: begin
        s_nxt.bits = {s_r.bits[DEPTH-2:0], 1'b1};
        if (s_r.fill >= 6'(DEPTH)) s_nxt.ovf = 1'b1;
        else s_nxt.fill = s_r.fill + 6'h01;
      end
      // [R18] two bits per call
      STK_CALL: begin
        s_nxt.bits = {s_r.bits[DEPTH-3:0], 2'h3};
        if (s_r.fill > 6'(DEPTH - 2)) s_nxt.ovf = 1'b1;
        else s_nxt.fill = s_r.fill + 6'h02;
      end
      STK_POP, STK_DEC: begin
        s_nxt.bits = {1'b0, s_r.bits[DEPTH-1:1]};
        // [R19] underflow detect
        if (s_r.fill == 6'h00) s_nxt.unf = 1'b1;
        else s_nxt.fill = s_r.fill - 6'h01;
      end
      STK_RET: begin
        s_nxt.bits = {2'h0, s_r.bits[DEPTH-1:2]};
        if (s_r.fill < 6'h02) begin
          s_nxt.unf  = 1'b1;
          s_nxt.fill = 6'h00;
        end else s_nxt.fill = s_r.fill - 6'h02;
      end
      default: s_nxt = s_nxt;
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign overflow_o  = s_r.ovf;
  assign underflow_o = s_r.unf;
  assign record_o    = s_r.bits;
endmodule

// >>> rtl/memspace_decoder.sv
// operand address decoding, memory map and stack pointer for the core
`timescale 1ns/100ps
// Functional notes
// [R01] relative jump offset is signed 8-bit
// [R02] direct low half RAM, high half registers
// [R03] page jumps stay in 2K page
// [R04] long jumps load full 16 bits
// [R05] opcode A5 decodes as no-op
// [R06] indirect address from bank register 0/1
// [R07] program store spans 0000 to 807F
// [R08] software avoids factory area 7E00-7FFF
// [R09] store-enable routes external writes to program
// [R10] lower 128 bytes direct and indirect
// [R11] 00-1F hold four eight-register banks
// [R12] status bits 3,4 select bank
// [R13] indirect above 7F reaches upper RAM
// [R14] bytes 20-2F bit-addressable 00-7F
// [R15] bit or byte set by instruction type
// [R16] stack pointer marks last used location
// [R17] stack pointer resets to 07
// [R18] record shifts one or two bits
// [R19] record flags overflow and underflow
// [R20] registers at x0/x8 bit-addressable
// [R21] software avoids unoccupied register addresses
// [R22] program/data chosen by instruction type
// [R23] upper bit addresses map to registers
module memspace_decoder (
  input  wire logic                        SYS_CLK_I,
  input  wire logic                        NRST_I,
  input  wire logic [7:0]                  OPCODE_I,
  input  wire memspace_pkg::access_kind_t  ACCESS_I,
  input  wire logic                        WRITE_I,
  input  wire logic [7:0]                  OPERAND_ADDR_I,
  input  wire logic [2:0]                  REG_NUM_I,
  input  wire logic                        INDEX_SEL_I,
  input  wire logic [7:0]                  INDEX_VALUE_I,
  input  wire logic [15:0]                 LONG_ADDR_I,
  input  wire memspace_pkg::jump_kind_t    JUMP_I,
  input  wire logic [15:0]                 NEXT_PC_I,
  input  wire logic [15:0]                 JUMP_OPERAND_I,
  input  wire memspace_pkg::stack_op_t     STACK_OP_I,
  input  wire logic                        SFR_WE_I,
  input  wire logic [7:0]                  SFR_WDATA_I,
  output logic                             NOP_O,
  output memspace_pkg::target_t            TARGET_O,
  output logic [15:0]                      MEM_ADDR_O,
  output logic                             BIT_ACCESS_O,
  output logic [2:0]                       BIT_POS_O,
  output logic                             BIT_ADDRESSABLE_O,
  output logic                             FLASH_HIT_O,
  output logic                             FACTORY_HIT_O,
  output logic [15:0]                      JUMP_TARGET_O,
  output logic [7:0]                       STACK_POINTER_O,
  output logic [7:0]                       STACK_ADDR_O,
  output logic [1:0]                       BANK_O,
  output logic                             STORE_WE_O,
  output logic                             STACK_OVERFLOW_O,
  output logic                             STACK_UNDERFLOW_O,
  output logic [31:0]                      STACK_RECORD_O
);
  import memspace_pkg::*;

  typedef struct packed {
    logic [7:0]  sp;
    logic [7:0]  status;
    logic [7:0]  pstore;
    target_t     tgt;
    logic [15:0] addr;
    logic        bit_acc;
    logic [2:0]  bit_pos;
    logic        bit_ok;
  } dec_state_t;

  dec_state_t s_r, s_nxt;

  // bank register byte address in low RAM
  function automatic logic [7:0] bank_reg(input logic [1:0] bank,
                                          input logic [2:0] num);
    bank_reg = {3'h0, bank, num};
  endfunction

  // registers at x0/x8 accept bit access
  function automatic logic sfr_bit_ok(input logic [7:0] a);
    sfr_bit_ok = (a[2:0] == 3'h0);
  endfunction

  logic [1:0] bank;
  logic [7:0] sp_plus;
  logic [7:0] sp_minus;

  // [R12] bank from status bits
  assign bank     = {s_r.status[BANK_HI_BIT], s_r.status[BANK_LO_BIT]};
  assign sp_plus  = s_r.sp + 8'h01;
  assign sp_minus = s_r.sp - 8'h01;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.tgt     = TGT_NONE;
    s_nxt.addr    = 16'h0000;
    s_nxt.bit_acc = 1'b0;
    s_nxt.bit_pos = 3'h0;
    s_nxt.bit_ok  = 1'b0;

    // register writes from the execution side
    if (SFR_WE_I) begin
      if (OPERAND_ADDR_I == STACK_PTR_ADDR) s_nxt.sp = SFR_WDATA_I;
      if (OPERAND_ADDR_I == STATUS_ADDR)    s_nxt.status = SFR_WDATA_I;
      if (OPERAND_ADDR_I == PSTORE_ADDR)    s_nxt.pstore = SFR_WDATA_I;
    end

    // [R16] pre-increment push
    case (STACK_OP_I)
      STK_PUSH, STK_INC: s_nxt.sp = sp_plus;
      STK_CALL:          s_nxt.sp = s_r.sp + 8'h02;
      STK_POP, STK_DEC:  s_nxt.sp = sp_minus;
      STK_RET:           s_nxt.sp = s_r.sp - 8'h02;
      default:           s_nxt.sp = s_nxt.sp;
    endcase

    // [R22] space follows instruction type
    case (ACCESS_I)
      ACC_DIRECT: begin
        s_nxt.addr = {8'h00, OPERAND_ADDR_I};
        // [R02] direct split at 80
        if (OPERAND_ADDR_I < DIRECT_SPLIT) s_nxt.tgt = TGT_LOW_RAM;
        else s_nxt.tgt = TGT_SFR;
      end
      ACC_INDIRECT: begin
        // [R06] index from bank register 0/1
        s_nxt.addr = {8'h00, INDEX_VALUE_I};
        // [R13] indirect high half is upper RAM
        if (INDEX_VALUE_I < DIRECT_SPLIT) s_nxt.tgt = TGT_LOW_RAM;
        else s_nxt.tgt = TGT_HIGH_RAM;
      end
      ACC_REG: begin
        // [R11] bank register location
        s_nxt.tgt  = TGT_LOW_RAM;
        s_nxt.addr = {8'h00, bank_reg(bank, REG_NUM_I)};
      end
      ACC_BIT: begin
        // [R15] bit form from instruction type
        s_nxt.bit_acc = 1'b1;
        s_nxt.bit_pos = OPERAND_ADDR_I[2:0];
        if (OPERAND_ADDR_I < DIRECT_SPLIT) begin
          // [R14] bit 8k+n in byte 20+k
          s_nxt.tgt    = TGT_LOW_RAM;
          s_nxt.addr   = {8'h00, BITRAM_BASE + {4'h0, OPERAND_ADDR_I[6:3]}};
          s_nxt.bit_ok = 1'b1;
        end else begin
          // [R23] clear low three bits
          s_nxt.tgt    = TGT_SFR;
          s_nxt.addr   = {8'h00, OPERAND_ADDR_I[7:3], 3'h0};
          s_nxt.bit_ok = 1'b1;
        end
      end
      ACC_EXT: begin
        s_nxt.addr = LONG_ADDR_I;
        // [R09] store-enable steers writes
        if (WRITE_I && s_r.pstore[PSTORE_WE_BIT]) s_nxt.tgt = TGT_PROG;
        else s_nxt.tgt = TGT_XDATA;
      end
      ACC_CODE: begin
        s_nxt.tgt  = TGT_PROG;
        s_nxt.addr = LONG_ADDR_I;
      end
      default: s_nxt.tgt = TGT_NONE;
    endcase

    // [R20] direct byte access to x0/x8 reports bit capability
    if (ACCESS_I == ACC_DIRECT && OPERAND_ADDR_I >= DIRECT_SPLIT)
      s_nxt.bit_ok = sfr_bit_ok(OPERAND_ADDR_I);
    // [R10] low half always byte-usable, but only 20-2F report bit capability
    if (ACCESS_I == ACC_DIRECT && OPERAND_ADDR_I < DIRECT_SPLIT)
      s_nxt.bit_ok = (OPERAND_ADDR_I[7:4] == BITRAM_BASE[7:4]);
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_r        <= '0;
      // [R17] reset value 07
      s_r.sp     <= STACK_PTR_RESET;
      s_r.tgt    <= TGT_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // [R05] A5 treated as no-op
  assign NOP_O = (OPCODE_I == OPC_NOP) || (OPCODE_I == OPC_SPARE_NOP);

  // [R07] program store range
  assign FLASH_HIT_O   = (s_r.tgt == TGT_PROG) && (s_r.addr <= FLASH_LAST);
  // reported only; protection is left to software
  assign FACTORY_HIT_O = (s_r.tgt == TGT_PROG) &&
                         (s_r.addr >= FACTORY_FIRST) &&
                         (s_r.addr <= FACTORY_LAST);

  assign TARGET_O          = s_r.tgt;
  assign MEM_ADDR_O        = s_r.addr;
  assign BIT_ACCESS_O      = s_r.bit_acc;
  assign BIT_POS_O         = s_r.bit_pos;
  assign BIT_ADDRESSABLE_O = s_r.bit_ok;
  assign STACK_POINTER_O   = s_r.sp;
  // push location is one past the last used byte
  assign STACK_ADDR_O      = sp_plus;
  assign BANK_O            = bank;
  assign STORE_WE_O        = s_r.pstore[PSTORE_WE_BIT];

  // INDEX_SEL_I is only sunk here; the index value arrives on INDEX_VALUE_I
  logic unused_index;
  assign unused_index = INDEX_SEL_I;

  jump_target u_jump (
    .kind_i    (JUMP_I),
    .next_pc_i (NEXT_PC_I),
    .operand_i (JUMP_OPERAND_I),
    .target_o  (JUMP_TARGET_O)
  );

  stack_record #(
    .DEPTH (REC_W)
  ) u_record (
    .clk_i       (SYS_CLK_I),
    .nrst_i      (NRST_I),
    .op_i        (STACK_OP_I),
    .overflow_o  (STACK_OVERFLOW_O),
    .underflow_o (STACK_UNDERFLOW_O),
    .record_o    (STACK_RECORD_O)
  );
endmodule

// >>> tb/memspace_decoder_sva.sv
// property checks on the memory space decoder ports
`timescale 1ns/100ps
module memspace_decoder_sva
  import memspace_pkg::*;
(
  input wire logic                       SYS_CLK_I,
  input wire logic                       NRST_I,
  input wire logic [7:0]                 OPCODE_I,
  input wire memspace_pkg::access_kind_t ACCESS_I,
  input wire logic [7:0]                 OPERAND_ADDR_I,
  input wire logic [7:0]                 INDEX_VALUE_I,
  input wire memspace_pkg::jump_kind_t   JUMP_I,
  input wire logic [15:0]                NEXT_PC_I,
  input wire logic [15:0]                JUMP_OPERAND_I,
  input wire memspace_pkg::stack_op_t    STACK_OP_I,
  input wire logic                       NOP_O,
  input wire memspace_pkg::target_t      TARGET_O,
  input wire logic [15:0]                JUMP_TARGET_O,
  input wire logic [7:0]                 STACK_POINTER_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  property p_dir_low;
    ACCESS_I == ACC_DIRECT && !OPERAND_ADDR_I[7] |=> TARGET_O == TGT_LOW_RAM;
  endproperty
  a_dir_low: assert property (p_dir_low) else $error("direct low");
  property p_dir_sfr;
    ACCESS_I == ACC_DIRECT && OPERAND_ADDR_I[7] |=> TARGET_O == TGT_SFR;
  endproperty
  a_dir_sfr: assert property (p_dir_sfr) else $error("direct high");
  property p_ind;
    ACCESS_I == ACC_INDIRECT && INDEX_VALUE_I[7] |=> TARGET_O == TGT_HIGH_RAM;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect high");
  property p_nop; OPCODE_I == OPC_SPARE_NOP |-> NOP_O; endproperty
  a_nop: assert property (p_nop) else $error("spare opcode");
  // 8-bit sum so a pointer at FF wraps to 00 as the hardware does
  property p_push;
    STACK_OP_I == STK_PUSH |=>
      STACK_POINTER_O == $past(STACK_POINTER_O) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push pointer");
  property p_pop;
    STACK_OP_I == STK_POP |=>
      STACK_POINTER_O == $past(STACK_POINTER_O) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer");
  property p_rel;
    JUMP_I == JUMP_REL |-> JUMP_TARGET_O ==
      NEXT_PC_I + {{8{JUMP_OPERAND_I[7]}}, JUMP_OPERAND_I[7:0]};
  endproperty
  a_rel: assert property (p_rel) else $error("relative jump");
  property p_page;
    JUMP_I == JUMP_PAGE |->
      JUMP_TARGET_O == {NEXT_PC_I[15:11], JUMP_OPERAND_I[10:0]};
  endproperty
  a_page: assert property (p_page) else $error("page jump");
  c_push: cover property (STACK_OP_I == STK_PUSH);
  c_ind: cover property (ACCESS_I == ACC_INDIRECT && INDEX_VALUE_I[7]);
  c_page: cover property (JUMP_I == JUMP_PAGE);
endmodule

bind memspace_decoder memspace_decoder_sva u_sva (
  .SYS_CLK_I, .NRST_I, .OPCODE_I, .ACCESS_I, .OPERAND_ADDR_I, .INDEX_VALUE_I,
  .JUMP_I, .NEXT_PC_I, .JUMP_OPERAND_I, .STACK_OP_I, .NOP_O, .TARGET_O,
  .JUMP_TARGET_O, .STACK_POINTER_O
);

// >>> tb/data_ram_model.sv
// working register bytes that feed the index value
`timescale 1ns/100ps
module data_ram_model (
  input  wire logic [1:0] bank_i,
  input  wire logic       sel_i,
  output logic      [7:0] index_value_o
);
  assign index_value_o = {bank_i, 2'b00, sel_i, 3'b000};
endmodule

// >>> tb/tb_memspace_decoder.sv
// self-checking bench for the memory space decoder
`timescale 1ns/100ps
module tb_memspace_decoder;
  import memspace_pkg::*;
  logic         clk = 1'b0;
  logic         nrst, we, isel, swr, nop, ba, bad, fh, fy, swe, ov, un;
  logic [31:0]  rec;
  logic [7:0]   opc, addr, ival, wd, sp, spa, e;
  logic [2:0]   rn, bp;
  logic [1:0]   bank;
  logic [15:0]  la, npc, jop, ma, jt;
  access_kind_t acc;
  jump_kind_t   jk;
  stack_op_t    so;
  target_t      tgt;
  int           fail_count = 0;
  int           checked = 0;

  memspace_decoder u_dut (.SYS_CLK_I(clk), .NRST_I(nrst), .OPCODE_I(opc),
    .ACCESS_I(acc), .WRITE_I(we), .OPERAND_ADDR_I(addr), .REG_NUM_I(rn),
    .INDEX_SEL_I(isel), .INDEX_VALUE_I(ival), .LONG_ADDR_I(la), .JUMP_I(jk),
    .NEXT_PC_I(npc), .JUMP_OPERAND_I(jop), .STACK_OP_I(so), .SFR_WE_I(swr),
    .SFR_WDATA_I(wd), .NOP_O(nop), .TARGET_O(tgt), .MEM_ADDR_O(ma),
    .BIT_ACCESS_O(ba), .BIT_POS_O(bp), .BIT_ADDRESSABLE_O(bad),
    .FLASH_HIT_O(fh), .FACTORY_HIT_O(fy), .JUMP_TARGET_O(jt),
    .STACK_POINTER_O(sp), .STACK_ADDR_O(spa), .BANK_O(bank),
    .STORE_WE_O(swe), .STACK_OVERFLOW_O(ov), .STACK_UNDERFLOW_O(un),
    .STACK_RECORD_O(rec));
  data_ram_model u_ram (.bank_i(bank), .sel_i(isel), .index_value_o(ival));

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    checked++;
    if (x !== g) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // outputs are registered, so look one falling edge later
  task automatic dec(access_kind_t k, logic [7:0] a, logic [15:0] l,
                     target_t t, logic [15:0] m);
    acc = k;
    addr = a;
    la = l;
    @(negedge clk);
    chk("target", 16'(t), 16'(tgt));
    chk("mem_addr", m, ma);
  endtask

  task automatic special_function_register(logic [7:0] a, logic [7:0] d);
    addr = a;
    wd = d;
    swr = 1;
    @(negedge clk);
    swr = 0;
  endtask

  // op is held, never dropped, so back-to-back calls stay clean
  task automatic stk(stack_op_t o, int n);
    so = o;
    repeat (n) @(negedge clk);
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    test_done();
  end

  initial begin
    {we, isel, swr, wd, addr, rn, la, npc, jop, opc} = '0;
    acc = ACC_NONE;
    jk = JUMP_NONE;
    so = STK_NONE;
    nrst = 0;
    repeat (10) @(negedge clk);
    nrst = 1;
    chk("sp", 8'h07, sp);
    chk("sp_next", 8'h08, spa);
    chk("record", 32'h0, rec);
    stk(STK_PUSH, 1);
    chk("sp", 8'h08, sp);
    chk("sp_next", 8'h09, spa);
    chk("record", 32'h1, rec);
    stk(STK_DEC, 1);
    stk(STK_POP, 1);
    chk("underflow", 1, un);
    stk(STK_INC, 2);
    chk("record", 32'h3, rec);
    stk(STK_RET, 1);
    chk("underflow", 0, un);
    chk("record", 32'h0, rec);
    chk("sp", 8'h06, sp);
    stk(STK_PUSH, 1);
    stk(STK_RET, 1);
    chk("underflow", 1, un);
    stk(STK_CALL, 16);
    chk("overflow", 0, ov);
    chk("record", 32'hFFFFFFFF, rec);
    stk(STK_PUSH, 1);
    chk("overflow", 1, ov);
    chk("sp", 8'h26, sp);
    stk(STK_NONE, 1);
    chk("overflow", 0, ov);
    special_function_register(STACK_PTR_ADDR, 8'h2F);
    chk("sp", 8'h2F, sp);
    chk("sp_next", 8'h30, spa);
    $display("stack tests done");
    dec(ACC_DIRECT, 8'h7F, 16'h0, TGT_LOW_RAM, 16'h007F);
    dec(ACC_DIRECT, 8'h2F, 16'h0, TGT_LOW_RAM, 16'h002F);
    chk("bit_capable", 1, bad);
    dec(ACC_DIRECT, 8'h80, 16'h0, TGT_SFR, 16'h0080);
    dec(ACC_BIT, 8'h13, 16'h0, TGT_LOW_RAM, 16'h0022);
    chk("bit_pos", 3, bp);
    chk("bit_access", 1, ba);
    chk("bit_capable", 1, bad);
    dec(ACC_BIT, 8'h8F, 16'h0, TGT_SFR, 16'h0088);
    chk("bit_pos", 7, bp);
    dec(ACC_DIRECT, 8'h88, 16'h0, TGT_SFR, 16'h0088);
    chk("bit_access", 0, ba);
    chk("bit_capable", 1, bad);
    // direct access to unoccupied 82, not at x0/x8, reports no bit capability
    dec(ACC_DIRECT, 8'h82, 16'h0, TGT_SFR, 16'h0082);
    chk("bit_capable", 0, bad);
    dec(ACC_NONE, 8'h82, 16'h0, TGT_NONE, 16'h0000);
    dec(ACC_CODE, 8'h7F, 16'h807F, TGT_PROG, 16'h807F);
    chk("flash", 1, fh);
    chk("factory", 0, fy);
    dec(ACC_CODE, 8'h7F, 16'h8080, TGT_PROG, 16'h8080);
    chk("flash", 0, fh);
    chk("factory", 0, fy);
    dec(ACC_CODE, 8'h7F, 16'h7E00, TGT_PROG, 16'h7E00);
    chk("factory", 1, fy);
    dec(ACC_CODE, 8'h7F, 16'h7FFF, TGT_PROG, 16'h7FFF);
    chk("factory", 1, fy);
    chk("flash", 1, fh);
    we = 1;
    dec(ACC_EXT, 8'h00, 16'h1234, TGT_XDATA, 16'h1234);
    special_function_register(PSTORE_ADDR, 8'h01);
    chk("store_we", 1, swe);
    dec(ACC_EXT, 8'h00, 16'h1234, TGT_PROG, 16'h1234);
    we = 0;
    dec(ACC_EXT, 8'h00, 16'h1234, TGT_XDATA, 16'h1234);
    isel = 1;
    rn = 3'h5;
    for (int b = 0; b < 4; b++) begin
      special_function_register(STATUS_ADDR, 8'(b * 8));
      chk("bank", 16'(b), bank);
      e = 8'(b * 64 + 8);
      dec(ACC_REG, 8'h00, 16'h0, TGT_LOW_RAM, 16'(b * 8 + 5));
      dec(ACC_INDIRECT, 8'h00, 16'h0, e[7] ? TGT_HIGH_RAM : TGT_LOW_RAM,
          {8'h00, e});
    end
    // mid-run reset must restore pointer, bank and store enable
    nrst = 0;
    repeat (2) @(negedge clk);
    chk("sp", 8'h07, sp);
    nrst = 1;
    chk("bank", 0, bank);
    chk("store_we", 0, swe);
    chk("target", 16'(TGT_NONE), 16'(tgt));
    jk = JUMP_REL;
    npc = 16'h17FE;
    jop = 16'hA580;
    #1;
    chk("rel_jump", 16'h177E, jt);
    @(negedge clk);
    jk = JUMP_PAGE;
    #1;
    chk("page_jump", 16'h1580, jt);
    @(negedge clk);
    jk = JUMP_LONG;
    opc = 8'hA5;
    #1;
    chk("long_jump", 16'hA580, jt);
    chk("nop", 1, nop);
    @(negedge clk);
    opc = 8'h01;
    #1;
    chk("nop", 0, nop);
    $display("decode tests done");
    test_done();
  end
endmodule
